// File: pc_stack_pkg.sv
package pc_stack_pkg;

   // ************************************************************
   // widths and depths
   // ************************************************************
   localparam int PC_WIDTH       = 13;
   localparam int LOW_WIDTH      = 8;
   localparam int HIGH_WIDTH     = 5;
   localparam int BRANCH_WIDTH   = 11;
   localparam int PAGE_WIDTH     = 2;
   localparam int STACK_DEPTH    = 8;
   localparam int PTR_WIDTH      = 3;

   // ************************************************************
   // field positions inside the high latch
   // ************************************************************
   localparam int PAGE_LSB       = 3;

   // ************************************************************
   // reset values and default interrupt vector
   // ************************************************************
   localparam logic [12:0] PC_RESET    = 13'h0000;
   localparam logic [4:0]  LATCH_RESET = 5'h00;
   localparam logic [2:0]  PTR_RESET   = 3'h0;
   localparam logic [12:0] VECTOR_DEF  = 13'h0004;

   // ************************************************************
   // sequencing operation from the decoder
   // ************************************************************
   typedef enum logic [2:0] {
      OP_STEP,
      OP_JUMP,
      OP_CALL,
      OP_RETURN,
      OP_LOW_WRITE,
      OP_IRQ,
      OP_HOLD
   } seq_op_e;

   typedef struct packed {
      seq_op_e     op;
      logic [10:0] target;
      logic [7:0]  lowData;
   } seq_req_s;

   typedef struct packed {
      logic        latchWrite;
      logic [4:0]  latchData;
   } latch_req_s;

endpackage

// File: return_stack.sv
`timescale 1ns/1ps
module return_stack #(
   parameter int DEPTH = pc_stack_pkg::STACK_DEPTH,
   parameter int WIDTH = pc_stack_pkg::PC_WIDTH
) (
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] pushData,
   output logic      [WIDTH-1:0] topData
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    ptr_q;
   logic [PW-1:0]    ptr_d;

   // pointer next value; no overflow or underflow flag exists
   always_comb begin
      ptr_d = ptr_q;
      if (push) begin
         ptr_d = PW'(ptr_q + 1'b1);
      end else if (pop) begin
         ptr_d = PW'(ptr_q - 1'b1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ptr_q <= PW'(pc_stack_pkg::PTR_RESET);
      end else begin
         ptr_q <= ptr_d;
      end
   end

   // entries are not cleared: stale values are legal after underflow
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[PW'(ptr_q + 1'b1)] <= pushData;
      end
   end

   // top entry at the current pointer feeds a pop
   assign topData = mem[ptr_q];

endmodule

// File: pc_stack_paging.sv
`timescale 1ns/1ps
// Functional notes
// - 13-bit pc, low byte readable and writable
// - high pc bits never readable by software
// - every reset clears the high pc bits
// - low byte write loads high from latch
// - call/jump: 11 instruction bits, latch page bits
// - arithmetic low byte write is computed jump
// - eight entry 13-bit private return stack
// - stack pointer hidden from software entirely
// - push pc+1 on call or interrupt branch
// - pop stack on any return kind
// - push and pop leave latch unchanged
// - circular stack, ninth push overwrites first
// - no overflow or underflow indication
// - pc spans 8K contiguous program words
// - return restores all 13 bits from stack
module pc_stack_paging #(
   parameter logic [12:0] VECTOR = pc_stack_pkg::VECTOR_DEF
) (
   input  wire logic                    clk_sys,
   input  wire logic                    srst,
   input  wire pc_stack_pkg::seq_req_s  seqReq,
   input  wire pc_stack_pkg::latch_req_s latchReq,
   output logic [12:0]                  fetchAddr,
   output logic [7:0]                   pcLowRead,
   output logic [4:0]                   latchRead
);

   // ************************************************************
   // state
   // ************************************************************
   logic [12:0] pc_q;
   logic [12:0] pc_d;
   logic [4:0]  pcHighLatch_q;
   logic [4:0]  pcHighLatch_d;
   logic [7:0]  lowRead_q;
   logic [7:0]  lowRead_d;
   logic [12:0] stackTop;
   logic        doPush;
   logic        doPop;
   logic [12:0] pcInc;

   assign pcInc  = 13'(pc_q + 1'b1);                  // 8K space wraps
   assign doPush = (seqReq.op == pc_stack_pkg::OP_CALL) ||
                   (seqReq.op == pc_stack_pkg::OP_IRQ);
   assign doPop  = (seqReq.op == pc_stack_pkg::OP_RETURN);

   // ************************************************************
   // return stack
   // ************************************************************
   // pointer lives inside the stack with no port out
   return_stack #(
      .DEPTH (pc_stack_pkg::STACK_DEPTH),
      .WIDTH (pc_stack_pkg::PC_WIDTH)
   ) u_stack (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .push     (doPush),
      .pop      (doPop),
      .pushData (pcInc),                               // return address
      .topData  (stackTop)
   );

   // ************************************************************
   // program counter next value
   // ************************************************************
   // one op per cycle, decoder guarantees page bits set
   always_comb begin
      pc_d = pc_q;
      unique case (seqReq.op)
         pc_stack_pkg::OP_STEP: begin
            pc_d = pcInc;
         end
         pc_stack_pkg::OP_JUMP,
         pc_stack_pkg::OP_CALL: begin
            pc_d = {pcHighLatch_q[pc_stack_pkg::PAGE_LSB +: pc_stack_pkg::PAGE_WIDTH],
                    seqReq.target};
         end
         pc_stack_pkg::OP_RETURN: begin
            pc_d = stackTop;                           // latch ignored
         end
         pc_stack_pkg::OP_LOW_WRITE: begin
            // add result or move both land here: computed jump
            pc_d = {pcHighLatch_q, seqReq.lowData};
         end
         pc_stack_pkg::OP_IRQ: begin
            pc_d = VECTOR;
         end
         pc_stack_pkg::OP_HOLD: begin
            pc_d = pc_q;
         end
         default: begin
            pc_d = pc_q;                               // illegal code: hold
         end
      endcase
   end

   // ************************************************************
   // high latch: only software writes touch it
   // ************************************************************
   always_comb begin
      pcHighLatch_d = pcHighLatch_q;
      if (latchReq.latchWrite) begin
         pcHighLatch_d = latchReq.latchData;
      end
   end

   // low byte read path; high bits never exposed
   always_comb begin
      lowRead_d = pc_d[7:0];
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pc_q          <= pc_stack_pkg::PC_RESET;
         pcHighLatch_q <= pc_stack_pkg::LATCH_RESET;
         lowRead_q     <= pc_stack_pkg::PC_RESET[7:0];
      end else begin
         pc_q          <= pc_d;
         pcHighLatch_q <= pcHighLatch_d;
         lowRead_q     <= lowRead_d;
      end
   end

   assign fetchAddr = pc_q;
   assign pcLowRead = lowRead_q;
   assign latchRead = pcHighLatch_q;

endmodule

// File: pc_stack_paging_sva.sv
`timescale 1ns/1ps
module pc_stack_paging_sva #(
   parameter logic [12:0] VECTOR = pc_stack_pkg::VECTOR_DEF
) (
   input wire logic                     clk_sys,
   input wire logic                     srst,
   input wire pc_stack_pkg::seq_req_s   seqReq,
   input wire pc_stack_pkg::latch_req_s latchReq,
   input wire logic [12:0]              fetchAddr,
   input wire logic [7:0]               pcLowRead,
   input wire logic [4:0]               latchRead
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   wire pc_stack_pkg::seq_op_e op = seqReq.op;
   // ************
   // pc, read and latch checks; op checks judged one cycle after the op
   // ************
   a_reset_clear: assert property ($fell(srst) |-> fetchAddr == 13'h0000 && latchRead == 5'h00)
      else $error("reset left pc or latch set");
   a_low_mirror: assert property (pcLowRead == fetchAddr[7:0])
      else $error("low byte differs from pc");
   a_low_write: assert property (op == pc_stack_pkg::OP_LOW_WRITE |=>
      fetchAddr == {$past(latchRead), $past(seqReq.lowData)}) else $error("low write load wrong");
   a_jump_page: assert property (op == pc_stack_pkg::OP_JUMP |=>
      fetchAddr == {$past(latchRead[4:3]), $past(seqReq.target)}) else $error("jump target wrong");
   a_step_wrap: assert property (op == pc_stack_pkg::OP_STEP |=>
      fetchAddr == $past(fetchAddr) + 13'h1) else $error("step wrong");
   a_irq_vector: assert property (op == pc_stack_pkg::OP_IRQ |=> fetchAddr == VECTOR)
      else $error("interrupt vector wrong");
   // a return right after a call must land just past the call, whatever the latch holds
   a_call_return: assert property (op == pc_stack_pkg::OP_CALL ##1
      op == pc_stack_pkg::OP_RETURN |=> fetchAddr == $past(fetchAddr, 2) + 13'h1)
      else $error("return address wrong");
   // an interrupt branch pushes too, so it must leave the latch alone as well
   a_latch_keep: assert property (op inside {pc_stack_pkg::OP_CALL, pc_stack_pkg::OP_RETURN,
      pc_stack_pkg::OP_IRQ} && !latchReq.latchWrite |=> $stable(latchRead)) else $error("stack op moved latch");
   c_call_return: cover property (op == pc_stack_pkg::OP_CALL ##1 op == pc_stack_pkg::OP_RETURN);
   c_irq: cover property (op == pc_stack_pkg::OP_IRQ);
   c_low_write: cover property (op == pc_stack_pkg::OP_LOW_WRITE && latchReq.latchWrite);
endmodule
bind pc_stack_paging pc_stack_paging_sva #(.VECTOR(VECTOR)) chk (.clk_sys(clk_sys), .srst(srst),
   .seqReq(seqReq), .latchReq(latchReq), .fetchAddr(fetchAddr), .pcLowRead(pcLowRead), .latchRead(latchRead));

// File: decoder_model.sv
`timescale 1ns/1ps
module decoder_model (
   input  wire pc_stack_pkg::seq_op_e    opCmd,
   input  wire logic [10:0]              target,
   input  wire logic                     latchWrite,
   input  wire logic [4:0]               latchData,
   output pc_stack_pkg::seq_req_s        seqReq,
   output pc_stack_pkg::latch_req_s      latchReq
);
   // page bits reach the latch before any far branch is issued
   // an add result for the low byte rides on the target's low bits
   assign seqReq = '{opCmd, target, target[7:0]};
   assign latchReq = '{latchWrite, latchData};
endmodule

// File: test_pc_stack_paging.sv
`timescale 1ns/1ps
module test_pc_stack_paging;
   logic                     clk_sys = 1'b0;
   logic                     srst = 1'b1;
   pc_stack_pkg::seq_op_e    op = pc_stack_pkg::OP_HOLD;
   logic [10:0]              tgt = 11'h000;
   logic                     lw = 1'b0;
   logic [4:0]               ld = 5'h00;
   pc_stack_pkg::seq_req_s   seqReq;
   pc_stack_pkg::latch_req_s latchReq;
   logic [12:0]              fetchAddr;
   logic [7:0]               pcLowRead;
   logic [4:0]               latchRead;
   logic [12:0]              ret [9];
   int                       miscompares = 0;
   int                       cmp_count = 0;
   always #5 clk_sys = ~clk_sys;
   decoder_model dec (.opCmd(op), .target(tgt), .latchWrite(lw), .latchData(ld), .seqReq(seqReq),
      .latchReq(latchReq));
   pc_stack_paging dut (.clk_sys(clk_sys), .srst(srst), .seqReq(seqReq), .latchReq(latchReq),
      .fetchAddr(fetchAddr), .pcLowRead(pcLowRead), .latchRead(latchRead));
   task automatic check(logic [12:0] seen, logic [12:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   // drive after the falling edge so the rising edge sees settled inputs
   task automatic issue(pc_stack_pkg::seq_op_e o, logic [10:0] t, logic w = 1'b0, logic [4:0] d = 5'h00);
      @(negedge clk_sys);
      op = o;
      tgt = t;
      lw = w;
      ld = d;
   endtask
   task automatic settle;
      issue(pc_stack_pkg::OP_HOLD, 11'h000);
   endtask
   task automatic t_paging;
      issue(pc_stack_pkg::OP_HOLD, 11'h000, 1'b1, 5'h15);
      issue(pc_stack_pkg::OP_LOW_WRITE, 11'h0ff, 1'b1, 5'h0a);
      issue(pc_stack_pkg::OP_STEP, 11'h000);
      check(fetchAddr, 13'h15ff);
      check({5'h00, pcLowRead}, 13'h00ff);
      issue(pc_stack_pkg::OP_JUMP, 11'h123);
      check(fetchAddr, 13'h1600);
      settle;
      check(fetchAddr, 13'h0923);
      srst = 1'b1;
      settle;
      srst = 1'b0;
      check(fetchAddr, 13'h0000);
      check({8'h00, latchRead}, 13'h0000);
      issue(pc_stack_pkg::OP_HOLD, 11'h000, 1'b1, 5'h1f);
      issue(pc_stack_pkg::OP_LOW_WRITE, 11'h0ff);
      issue(pc_stack_pkg::OP_STEP, 11'h000);
      settle;
      check(fetchAddr, 13'h0000);
      $display("paging test done");
   endtask
   // nine calls wrap the eight deep stack, then nine pops walk it round
   task automatic t_stack;
      for (int i = 0; i < 9; i++) begin
         settle;
         ret[i] = fetchAddr + 13'h1;
         issue(pc_stack_pkg::OP_CALL, 11'((i + 1) * 16));
      end
      issue(pc_stack_pkg::OP_HOLD, 11'h000, 1'b1, 5'h00);
      check(fetchAddr, 13'h1890);
      check({8'h00, latchRead}, 13'h001f);
      for (int i = 0; i < 9; i++) begin
         issue(pc_stack_pkg::OP_RETURN, 11'h000);
         settle;
         check(fetchAddr, ret[(i == 8) ? 8 : 8 - i]);
      end
      check({8'h00, latchRead}, 13'h0000);
      $display("stack test done");
   endtask
   task automatic t_irq;
      logic [12:0] p;
      p = fetchAddr;
      issue(pc_stack_pkg::OP_CALL, 11'h7ff);
      issue(pc_stack_pkg::OP_RETURN, 11'h000);
      settle;
      check(fetchAddr, p + 13'h1);
      issue(pc_stack_pkg::OP_IRQ, 11'h000);
      settle;
      check(fetchAddr, pc_stack_pkg::VECTOR_DEF);
      issue(pc_stack_pkg::OP_RETURN, 11'h000);
      settle;
      check(fetchAddr, p + 13'h2);
      $display("interrupt test done");
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      srst = 1'b0;
      check(fetchAddr, 13'h0000);
      t_paging;
      t_stack;
      t_irq;
      report_and_stop;
   end
endmodule
